// [mbpm_pkg.sv]
// constants and types shared by the host-side bus controller
// Operation
// - classic muxed bus: low address shares data pins, latched on address strobe.
// - single-read-strobe setups: every read uses the read strobe pin only.
// - address bit 16 may optionally be driven on port A bit zero.
// - two-read-strobe setup: data reads on read pin, fetches on fetch pin.
// - non-paged mode pulses the address strobe in every bus cycle.
// - paged mode: data shares A15-A8; page hit skips strobe, changes A7-A0.
// - burst host 8-bit: A3-A0 direct, A11-A4 share the data pins.
// - burst fetch holds upper address while A3-A0 step, up to 16 bytes.
// - enable plus read/write host runs the device as 8-bit muxed bus.
package mbpm_pkg;
   localparam int APB_AW = 8;
   localparam int CLK_NS = 25;
   // length of each bus phase; also covers the device access time
   localparam int PHASE_NS = 50;
   localparam int PHASE_CYC_RAW = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PHASE_CYC = (PHASE_CYC_RAW < 1) ? 1 : PHASE_CYC_RAW;
   localparam int BURST_MAX = 16;
   localparam int ADDR_W = 20;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_CMD = 8'h0c;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_RDATA = 8'h14;
   localparam logic [1:0] BURST_WIN = 2'h1;
   // field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_A16_EN = 4;
   localparam int CMD_GO = 0;
   localparam int CMD_WRITE = 1;
   localparam int CMD_FETCH = 2;
   localparam int CMD_LEN_LSB = 4;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_HIT = 2;
   typedef enum logic [2:0] {
      MODE_MUX,
      MODE_ONE_RD,
      MODE_ONE_RD_PAGED,
      MODE_TWO_RD_PAGED,
      MODE_BURST,
      MODE_E_RW
   } mbpm_mode_e;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_LATCH,
      ST_STROBE,
      ST_GAP
   } mbpm_state_e;
   localparam mbpm_mode_e CTRL_RESET_MODE = MODE_MUX;
endpackage : mbpm_pkg

// [mbpm_phase_tick.sv]
// phase divider: one-cycle enable pulse every CYC clocks while running
`timescale 1ns/1ps
`default_nettype none
module mbpm_phase_tick #(
   parameter int CYC = 2
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // control
   input  wire logic run,
   output logic      tick
);
   localparam int CW = $clog2(CYC + 1);
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic          next_tick;

   always_comb begin
      next_cnt = cnt;
      next_tick = 1'b0;
      if (!run) begin
         next_cnt = '0;
      end else if (cnt == CW'(CYC - 1)) begin
         next_cnt = '0;
         next_tick = 1'b1;
      end else begin
         next_cnt = cnt + CW'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule : mbpm_phase_tick
`default_nettype wire

// [mbpm_host.sv]
// host-side controller driving the 8-bit mcu bus pins, commanded over apb
`timescale 1ns/1ps
`default_nettype none
module mbpm_host #(
   parameter int PHASE_CYC = mbpm_pkg::PHASE_CYC
) (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        nrst,
   // apb slave
   input  wire logic [mbpm_pkg::APB_AW-1:0] paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // shared address/data port
   input  wire logic [7:0]                  ad_in,
   output logic      [7:0]                  ad_out,
   output logic                             ad_oe,
   // direct address pins and strobes
   output logic      [7:0]                  addr_direct_out,
   output logic                             port_a_bit_zero,
   output logic                             address_latch_strobe,
   output logic                             write_strobe_pin,
   output logic                             read_strobe_pin,
   output logic                             fetch_strobe_pin
);
   import mbpm_pkg::*;

   logic rst_meta;
   logic rst_n;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   function automatic logic is_paged(input mbpm_mode_e m);
      return (m == MODE_ONE_RD_PAGED) || (m == MODE_TWO_RD_PAGED);
   endfunction : is_paged

   function automatic logic one_rd(input mbpm_mode_e m);
      return (m == MODE_ONE_RD) || (m == MODE_ONE_RD_PAGED);
   endfunction : one_rd

   function automatic logic is_mapped(input logic [APB_AW-1:0] a);
      return (a[7:6] == BURST_WIN) || (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_WDATA) ||
             (a == REG_CMD) || (a == REG_STAT) || (a == REG_RDATA);
   endfunction : is_mapped

   // {shared port byte, direct pin byte} for the address phase of each bus type
   function automatic logic [15:0] addr_pins(input mbpm_mode_e m, input logic [ADDR_W-1:0] a);
      if (is_paged(m)) begin
         return {a[15:8], a[7:0]};
      end else if (m == MODE_BURST) begin
         return {a[11:4], 4'h0, a[3:0]};
      end
      return {a[7:0], a[15:8]};
   endfunction : addr_pins

   // register group
   mbpm_state_e       state;
   mbpm_mode_e        cfg_mode;
   mbpm_mode_e        next_cfg_mode;
   logic              cfg_a16;
   logic              next_cfg_a16;
   logic [ADDR_W-1:0] req_addr;
   logic [ADDR_W-1:0] next_req_addr;
   logic [7:0]        req_wdata;
   logic [7:0]        next_req_wdata;
   logic [31:0]       next_prdata;
   logic              next_pready;
   logic              next_pslverr;
   logic              done;
   logic              page_hit;
   logic [7:0]        rdata;
   logic [7:0]        burst_mem [BURST_MAX];
   logic              busy;
   logic              wr_acc;
   logic              go;
   logic              clr_done;

   assign busy = (state != ST_IDLE);
   assign wr_acc = psel && penable && pready && pwrite;
   // orders that arrive mid-cycle are dropped so the bus setup stays static
   assign go = wr_acc && (paddr == REG_CMD) && pwdata[CMD_GO] && !busy;
   assign clr_done = wr_acc && (paddr == REG_STAT) && pwdata[STAT_DONE];

   always_comb begin
      next_cfg_mode = cfg_mode;
      next_cfg_a16 = cfg_a16;
      next_req_addr = req_addr;
      next_req_wdata = req_wdata;
      next_prdata = prdata;
      next_pslverr = pslverr;
      // one wait state: data is prepared while pready is low
      next_pready = psel && penable && !pready;
      if (psel && penable && !pready) begin
         next_pslverr = !is_mapped(paddr);
         next_prdata = 32'h0;
         if (paddr[7:6] == BURST_WIN) begin
            next_prdata[7:0] = burst_mem[paddr[5:2]];
         end else begin
            unique case (paddr)
               REG_CTRL: begin
                  next_prdata[CTRL_MODE_LSB +: 3] = cfg_mode;
                  next_prdata[CTRL_A16_EN] = cfg_a16;
               end
               REG_ADDR: next_prdata[ADDR_W-1:0] = req_addr;
               REG_WDATA: next_prdata[7:0] = req_wdata;
               REG_STAT: begin
                  next_prdata[STAT_BUSY] = busy;
                  next_prdata[STAT_DONE] = done;
                  next_prdata[STAT_HIT] = page_hit;
               end
               REG_RDATA: next_prdata[7:0] = rdata;
               default: next_prdata = 32'h0;
            endcase
         end
      end
      if (wr_acc && !busy) begin
         if (paddr == REG_CTRL) begin
            next_cfg_mode = mbpm_mode_e'(pwdata[CTRL_MODE_LSB +: 3]);
            next_cfg_a16 = pwdata[CTRL_A16_EN];
         end
         if (paddr == REG_ADDR) begin
            next_req_addr = pwdata[ADDR_W-1:0];
         end
         if (paddr == REG_WDATA) begin
            next_req_wdata = pwdata[7:0];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_mode <= CTRL_RESET_MODE;
         cfg_a16 <= 1'b0;
         req_addr <= '0;
         req_wdata <= 8'h00;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         cfg_mode <= next_cfg_mode;
         cfg_a16 <= next_cfg_a16;
         req_addr <= next_req_addr;
         req_wdata <= next_req_wdata;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // bus cycle group
   logic              tick;
   mbpm_state_e       next_state;
   mbpm_mode_e        cur_mode;
   mbpm_mode_e        next_cur_mode;
   mbpm_mode_e        pin_mode;
   logic              cur_write;
   logic              next_cur_write;
   logic              cur_fetch;
   logic              next_cur_fetch;
   logic [ADDR_W-1:0] cur_addr;
   logic [ADDR_W-1:0] next_cur_addr;
   logic [7:0]        cur_wdata;
   logic [7:0]        next_cur_wdata;
   logic [3:0]        beat;
   logic [3:0]        next_beat;
   logic [3:0]        beats_left;
   logic [3:0]        next_beats_left;
   logic [7:0]        page_addr;
   logic [7:0]        next_page_addr;
   logic              page_valid;
   logic              next_page_valid;
   logic              next_done;
   logic              next_page_hit;
   logic [7:0]        next_rdata;
   logic [7:0]        next_burst_mem [BURST_MAX];
   logic [7:0]        next_ad_out;
   logic              next_ad_oe;
   logic [7:0]        next_addr_direct_out;
   logic              next_port_a_bit_zero;
   logic              next_latch_strobe;
   logic              next_write_pin;
   logic              next_read_pin;
   logic              next_fetch_pin;
   logic [15:0]       apins;
   logic              strobe_on;
   logic              hit_now;

   mbpm_phase_tick #(
      .CYC(PHASE_CYC)
   ) u_tick (
      .sys_clk(sys_clk),
      .rst_n  (rst_n),
      .run    (busy),
      .tick   (tick)
   );

   // a page hit reuses the upper byte latched by the previous cycle
   // bit 16 is latched on the same strobe, so a hit needs it unchanged as well
   assign hit_now = is_paged(cfg_mode) && page_valid && (page_addr == req_addr[15:8])
                    && (port_a_bit_zero == (cfg_a16 && req_addr[16]));

   always_comb begin
      next_state = state;
      next_cur_mode = cur_mode;
      next_cur_write = cur_write;
      next_cur_fetch = cur_fetch;
      next_cur_addr = cur_addr;
      next_cur_wdata = cur_wdata;
      next_beat = beat;
      next_beats_left = beats_left;
      next_page_addr = page_addr;
      next_page_valid = page_valid;
      next_page_hit = page_hit;
      next_rdata = rdata;
      next_burst_mem = burst_mem;
      next_done = done && !clr_done;
      unique case (state)
         ST_IDLE: begin
            if (go) begin
               next_cur_mode = cfg_mode;
               next_cur_write = pwdata[CMD_WRITE];
               next_cur_fetch = pwdata[CMD_FETCH];
               next_cur_addr = req_addr;
               next_cur_wdata = req_wdata;
               next_beat = 4'h0;
               next_page_hit = hit_now;
               next_beats_left = 4'h0;
               if ((cfg_mode == MODE_BURST) && pwdata[CMD_FETCH] && !pwdata[CMD_WRITE]) begin
                  next_beats_left = pwdata[CMD_LEN_LSB +: 4];
               end
               // non-paged types always pulse the address strobe
               next_state = hit_now ? ST_LATCH : ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (tick) begin
               next_state = ST_LATCH;
            end
         end
         ST_LATCH: begin
            if (tick) begin
               next_state = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (tick) begin
               // sampled a full phase after the low address settled
               if (!cur_write) begin
                  next_rdata = ad_in;
                  next_burst_mem[beat] = ad_in;
               end
               next_state = ST_GAP;
            end
         end
         ST_GAP: begin
            if (tick) begin
               if (beats_left != 4'h0) begin
                  next_beats_left = beats_left - 4'h1;
                  next_beat = beat + 4'h1;
                  // only the low nibble steps; upper bits stay latched in the device
                  next_cur_addr[3:0] = cur_addr[3:0] + 4'h1;
                  next_state = ST_STROBE;
               end else begin
                  next_state = ST_IDLE;
                  next_done = 1'b1;
                  next_page_addr = cur_addr[15:8];
                  next_page_valid = is_paged(cur_mode);
               end
            end
         end
      endcase
      // pins follow the next state so they stay aligned with the state register
      pin_mode = (next_state == ST_IDLE) ? cfg_mode : next_cur_mode;
      apins = addr_pins(next_cur_mode, next_cur_addr);
      strobe_on = (next_state == ST_STROBE);
      next_latch_strobe = (next_state == ST_ADDR);
      next_ad_out = ad_out;
      next_ad_oe = 1'b0;
      next_addr_direct_out = addr_direct_out;
      next_port_a_bit_zero = port_a_bit_zero;
      if (next_state == ST_ADDR || next_state == ST_LATCH) begin
         next_ad_out = apins[15:8];
         next_ad_oe = 1'b1;
      end else if ((next_state == ST_STROBE || next_state == ST_GAP) && next_cur_write) begin
         next_ad_out = next_cur_wdata;
         next_ad_oe = 1'b1;
      end
      if (next_state != ST_IDLE) begin
         next_addr_direct_out = apins[7:0];
         next_port_a_bit_zero = cfg_a16 && next_cur_addr[16];
      end
      if (pin_mode == MODE_E_RW) begin
         // write pin carries read/write level, read pin the enable strobe
         next_write_pin = !((next_state != ST_IDLE) && next_cur_write);
         next_read_pin = strobe_on;
         next_fetch_pin = 1'b1;
      end else begin
         next_write_pin = !(strobe_on && next_cur_write);
         next_read_pin = !(strobe_on && !next_cur_write && (!next_cur_fetch || one_rd(pin_mode)));
         next_fetch_pin = !(strobe_on && !next_cur_write && next_cur_fetch && !one_rd(pin_mode));
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         cur_mode <= CTRL_RESET_MODE;
         cur_write <= 1'b0;
         cur_fetch <= 1'b0;
         cur_addr <= '0;
         cur_wdata <= 8'h00;
         beat <= 4'h0;
         beats_left <= 4'h0;
         page_addr <= 8'h00;
         page_valid <= 1'b0;
         page_hit <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
         burst_mem <= '{default: 8'h00};
         ad_out <= 8'h00;
         ad_oe <= 1'b0;
         addr_direct_out <= 8'h00;
         port_a_bit_zero <= 1'b0;
         address_latch_strobe <= 1'b0;
         write_strobe_pin <= 1'b1;
         read_strobe_pin <= 1'b1;
         fetch_strobe_pin <= 1'b1;
      end else begin
         state <= next_state;
         cur_mode <= next_cur_mode;
         cur_write <= next_cur_write;
         cur_fetch <= next_cur_fetch;
         cur_addr <= next_cur_addr;
         cur_wdata <= next_cur_wdata;
         beat <= next_beat;
         beats_left <= next_beats_left;
         page_addr <= next_page_addr;
         page_valid <= next_page_valid;
         page_hit <= next_page_hit;
         done <= next_done;
         rdata <= next_rdata;
         burst_mem <= next_burst_mem;
         ad_out <= next_ad_out;
         ad_oe <= next_ad_oe;
         addr_direct_out <= next_addr_direct_out;
         port_a_bit_zero <= next_port_a_bit_zero;
         address_latch_strobe <= next_latch_strobe;
         write_strobe_pin <= next_write_pin;
         read_strobe_pin <= next_read_pin;
         fetch_strobe_pin <= next_fetch_pin;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   latch_each_cycle_a: assert property ((go && !is_paged(cfg_mode)) |=> address_latch_strobe)
      else $error("non-paged cycle without address strobe");
   page_hit_skip_a: assert property ((go && hit_now) |=> !address_latch_strobe [*4])
      else $error("address strobe pulsed on a page hit");
   single_strobe_a: assert property ((busy && one_rd(cur_mode)) |-> fetch_strobe_pin)
      else $error("fetch pin used in single read strobe setup");
   two_strobe_a: assert property ((state == ST_STROBE && cur_mode == MODE_TWO_RD_PAGED
                                  && cur_fetch && !cur_write) |-> (!fetch_strobe_pin && read_strobe_pin))
      else $error("fetch not on fetch pin");
   read_release_a: assert property ((state == ST_STROBE && !cur_write) |-> !ad_oe)
      else $error("host drives shared port during read");
   write_data_a: assert property ((!write_strobe_pin && cur_mode != MODE_E_RW)
                                 |-> (ad_oe && ad_out == cur_wdata))
      else $error("write strobe without write data");
   burst_step_a: assert property ((state == ST_GAP && tick && beats_left != 4'h0)
                                 |=> (addr_direct_out[3:0] == 4'($past(addr_direct_out[3:0]) + 4'h1)
                                      && $stable(ad_oe) && !address_latch_strobe))
      else $error("burst beat did not step low nibble");
   erw_dir_a: assert property ((cur_mode == MODE_E_RW && read_strobe_pin)
                              |-> (write_strobe_pin == !cur_write))
      else $error("direction line wrong during enable");
   a16_pin_a: assert property (busy |-> (port_a_bit_zero == (cfg_a16 && cur_addr[16])))
      else $error("port a bit zero not address bit 16");
   cfg_static_a: assert property (busy |=> $stable(cfg_mode))
      else $error("bus type changed during a cycle");
   apb_wait_a: assert property ((psel && penable && !pready) |=> pready)
      else $error("apb answer late");

   burst_done_c: cover property ((state == ST_GAP && beats_left == 4'h0 && cur_mode == MODE_BURST && beat != 4'h0) ##1 done);
   page_hit_c: cover property (go && hit_now);
   write_c: cover property (state == ST_STROBE && cur_write);
   erw_read_c: cover property (state == ST_STROBE && cur_mode == MODE_E_RW && !cur_write);
endmodule : mbpm_host
`default_nettype wire

// [mbpm_dev_model.sv]
// behavioural model of the programmable peripheral on the host's 8-bit bus
`timescale 1ns/1ps
`default_nettype none
module mbpm_dev_model
   import mbpm_pkg::*;
(
   // static bus configuration
   input  wire mbpm_pkg::mbpm_mode_e mode,
   // host bus pins
   input  wire logic [7:0]           ad_out,
   input  wire logic                 ad_oe,
   input  wire logic [7:0]           addr_direct_out,
   input  wire logic                 port_a_bit_zero,
   input  wire logic                 address_latch_strobe,
   input  wire logic                 write_strobe_pin,
   input  wire logic                 read_strobe_pin,
   input  wire logic                 fetch_strobe_pin,
   // data returned to the host
   output logic      [7:0]           ad_in
);
   logic [7:0]  mem [logic [19:0]];
   logic [7:0]  lb, db;
   logic        a16, rd, code;
   logic [19:0] cur;
   // device port A: bit zero is dedicated to the address 16 input, so its driver stays off
   logic [7:0]  port_a_dir;
   logic        port_a_pt;
   logic        port_a0_oe;
   logic        port_a0_in;
   assign port_a0_oe = port_a_pt | port_a_dir[0];
   assign port_a0_in = port_a0_oe ? 1'b0 : port_a_bit_zero;
   function automatic logic [7:0] pat(input logic [19:0] a, input logic c);
      return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]} ^ (c ? 8'h5a : 8'h00);
   endfunction : pat
   initial begin
      ad_in = 8'h00;
      lb = 8'h00;
      db = 8'h00;
      a16 = 1'b0;
      port_a_dir = 8'h00;
      port_a_pt = 1'b0;
   end
   // upper byte kept over strobe-less page and burst hits
   always @(negedge address_latch_strobe) begin
      lb = ad_out;
      db = addr_direct_out;
      a16 = port_a0_in;
   end
   always @* begin
      case (mode)
         MODE_ONE_RD_PAGED, MODE_TWO_RD_PAGED: cur = {3'h0, a16, lb, addr_direct_out};
         MODE_BURST: cur = {3'h0, a16, 4'h0, lb, addr_direct_out[3:0]};
         default: cur = {3'h0, a16, db, lb};
      endcase
      code = !fetch_strobe_pin && mode inside {MODE_MUX, MODE_TWO_RD_PAGED, MODE_BURST};
      rd = (mode == MODE_E_RW) ? (read_strobe_pin && write_strobe_pin) : (!read_strobe_pin || code);
   end
   // no pull on these pins: a released bus turns over instead of keeping the last byte
   always @(rd or cur or code) begin
      if (rd)
         ad_in <= #20 code ? pat(cur, 1'b1) : (mem.exists(cur) ? mem[cur] : pat(cur, 1'b0));
      else
         ad_in <= #5 ~ad_in;
   end
   always @(posedge write_strobe_pin)
      if (mode != MODE_E_RW && ad_oe)
         mem[cur] = ad_out;
   always @(negedge read_strobe_pin)
      if (mode == MODE_E_RW && !write_strobe_pin && ad_oe)
         mem[cur] = ad_out;
endmodule : mbpm_dev_model
`default_nettype wire

// [mcu_bus_and_port_mux_tb.sv]
// randomised self-checking bench for the host-side mcu bus controller
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_and_port_mux_tb;
   import mbpm_pkg::*;
   logic              sys_clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
   logic              ad_oe, port_a_bit_zero, address_latch_strobe;
   logic              write_strobe_pin, read_strobe_pin, fetch_strobe_pin;
   logic [APB_AW-1:0] paddr;
   logic [7:0]        ad_in, ad_out, addr_direct_out;
   logic [31:0]       pwdata, prdata, q, st, ctrl;
   logic [7:0]        em [logic [19:0]];
   mbpm_mode_e        md;
   int                miscompares, check_count;
   mbpm_host mbpm_host_i (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .ad_in, .ad_out, .ad_oe, .addr_direct_out, .port_a_bit_zero, .address_latch_strobe,
      .write_strobe_pin, .read_strobe_pin, .fetch_strobe_pin);
   mbpm_dev_model mbpm_dev_model_i (.mode(md), .ad_out, .ad_oe, .addr_direct_out, .port_a_bit_zero,
      .address_latch_strobe, .write_strobe_pin, .read_strobe_pin, .fetch_strobe_pin, .ad_in);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   function automatic logic [7:0] pat(input logic [19:0] a, input logic c);
      return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]} ^ (c ? 8'h5a : 8'h00);
   endfunction : pat
   function automatic logic [7:0] exp_rd(input logic [19:0] a, input logic f);
      if (f && md inside {MODE_MUX, MODE_TWO_RD_PAGED, MODE_BURST})
         return pat(a, 1'b1);
      return em.exists(a) ? em[a] : pat(a, 1'b0);
   endfunction : exp_rd
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         end_of_test();
      end
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // pb pokes the config while the cycle runs, which must be dropped
   task automatic cyc(input logic [19:0] a, input logic [2:0] c, input logic [3:0] len, input logic [7:0] wd,
                      input logic pb);
      int n;
      logic b;
      apb(1'b1, REG_ADDR, {12'h0, a});
      apb(1'b1, REG_WDATA, {24'h0, wd});
      apb(1'b1, REG_CMD, {24'h0, len, 1'b0, c});
      if (pb)
         apb(1'b1, REG_CTRL, 32'h0);
      n = 0;
      do begin
         apb(1'b0, REG_STAT, 32'h0);
         if (n == 0)
            b = q[STAT_BUSY];
         n++;
      end while (q[STAT_DONE] !== 1'b1 && n < 200);
      if (q[STAT_DONE] !== 1'b1) begin
         miscompares++;
         end_of_test();
      end
      st = q;
      chk({31'h0, b}, 32'h1);
      apb(1'b1, REG_STAT, 32'h2);
   endtask : cyc
   initial begin
      logic [19:0] a, e;
      logic [7:0]  w;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      md = MODE_MUX;
      miscompares = 0;
      check_count = 0;
      void'($urandom(64179));
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(q, {29'h0, CTRL_RESET_MODE});
      apb(1'b0, 8'h3c, 32'h0);
      chk({31'h0, perr}, 32'h1);
      chk(q, 32'h0);
      for (int m = 0; m < 6; m++) begin
         ctrl = {27'h0, 1'($urandom), 1'b0, 3'(m)};
         apb(1'b1, REG_CTRL, ctrl);
         md <= mbpm_mode_e'(m);
         a = 20'($urandom) & ((m == 4) ? 20'h10ff0 : 20'h1ffff);
         e = a & {3'h0, ctrl[CTRL_A16_EN], 16'hffff};
         w = 8'($urandom);
         cyc(a, 3'b011, 4'h0, w, 1'b0);
         em[e] = w;
         cyc(a ^ 20'h1, 3'b011, 4'h0, ~w, 1'b0);
         em[e ^ 20'h1] = ~w;
         for (int k = 0; k < 3; k++) begin
            cyc(a ^ 20'(k & 1), {k == 2, 2'b01}, 4'h0, 8'h00, m == 5 && k == 2);
            apb(1'b0, REG_RDATA, 32'h0);
            chk(q, {24'h0, exp_rd(e ^ 20'(k & 1), k == 2)});
            chk({31'h0, st[STAT_HIT]}, {31'h0, 1'(m == 2 || m == 3)});
         end
         if (m == 4) begin
            cyc(a, 3'b101, 4'hf, 8'h00, 1'b0);
            for (int i = 0; i < BURST_MAX; i++) begin
               apb(1'b0, 8'(8'h40 + 4 * i), 32'h0);
               chk(q, {24'h0, pat(e + 20'(i), 1'b1)});
            end
         end
         $display("mode %0d test done", m);
      end
      apb(1'b0, REG_CTRL, 32'h0);
      chk(q, ctrl);
      end_of_test();
   end
endmodule : mcu_bus_and_port_mux_tb
`default_nettype wire
